/* File: src/tte_pkg.sv */
// constants, cause codes and helpers shared by the tlb trap exception unit
package tte_pkg;

   // ******************************************************
   // register byte offsets
   // ******************************************************
   localparam logic [5:0] OFF_MSR   = 6'h00;
   localparam logic [5:0] OFF_SAVE_RESTORE_ADDRESS  = 6'h04;
   localparam logic [5:0] OFF_SAVE_RESTORE_STATUS  = 6'h08;
   localparam logic [5:0] OFF_MAR   = 6'h0c;
   localparam logic [5:0] OFF_MISS_STATUS_REGISTER  = 6'h10;
   localparam logic [5:0] OFF_CMP   = 6'h14;
   localparam logic [5:0] OFF_PRIMARY_HASH_ASSIST = 6'h18;
   localparam logic [5:0] OFF_SECONDARY_HASH_ASSIST = 6'h1c;
   localparam logic [5:0] OFF_LRUA  = 6'h20;
   localparam logic [5:0] OFF_LRUB  = 6'h24;
   localparam logic [5:0] OFF_FIELD = 6'h28;
   localparam logic [5:0] OFF_CAUSE = 6'h2c;

   // ******************************************************
   // field positions (bit 0 is the msb, index = 31 - bit)
   // ******************************************************
   localparam int unsigned MSR_IR_POS     = 31 - 26;
   localparam int unsigned MSR_DR_POS     = 31 - 27;
   localparam int unsigned MSR_EE_POS     = 31 - 16;
   localparam int unsigned MSR_PR_POS     = 31 - 17;
   localparam int unsigned MSR_INVBLK_POS = 31 - 14;
   localparam int unsigned MSR_TW_POS     = 31 - 13;
   localparam int unsigned SAVE_RESTORE_STATUS_BRK_POS   = 31 - 11;
   localparam int unsigned MISS_STATUS_REGISTER_DATA_POS  = 31 - 1;
   localparam int unsigned MISS_STATUS_REGISTER_FETCH_POS = 31 - 2;
   localparam int unsigned MISS_STATUS_REGISTER_PROT_POS  = 31 - 4;
   localparam int unsigned MISS_STATUS_REGISTER_STORE_POS = 31 - 6;
   localparam int unsigned MISS_STATUS_REGISTER_ELEM_LSB  = 31 - 8;

   // ******************************************************
   // save/restore status masks and reset values
   // ******************************************************
   localparam logic [31:0] SAVE_RESTORE_STATUS_TRACE_CLR = 32'h783f_0000;
   localparam logic [31:0] SAVE_RESTORE_STATUS_TLB_CLR   = 32'hf83f_0000;
   localparam logic [31:0] MSR_RESET      = 32'h0000_0000;
   localparam logic [31:0] REG_RESET      = 32'h0000_0000;

   // ******************************************************
   // vector offsets
   // ******************************************************
   localparam logic [15:0] VEC_DSI    = 16'h0300;
   localparam logic [15:0] VEC_ISI    = 16'h0400;
   localparam logic [15:0] VEC_ALIGN  = 16'h0600;
   localparam logic [15:0] VEC_TRACE  = 16'h0d00;
   localparam logic [15:0] VEC_TMISS  = 16'h1000;
   localparam logic [15:0] VEC_TSTORE = 16'h1100;

   // order of the causes is the priority, highest first
   typedef enum logic [3:0] {
      CS_NONE, CS_STEP, CS_ITLB, CS_ISI, CS_IBRK,
      CS_ALIGN, CS_DTLB, CS_TSTORE, CS_DSI, CS_DBRK
   } tte_cause_e;

   localparam int unsigned NUM_CAUSE = 9;

   function automatic logic [15:0] vecOf(input tte_cause_e c);
      case (c)
         CS_STEP, CS_IBRK:  vecOf = VEC_TRACE;
         CS_ITLB, CS_DTLB:  vecOf = VEC_TMISS;
         CS_TSTORE:         vecOf = VEC_TSTORE;
         CS_ISI:            vecOf = VEC_ISI;
         CS_ALIGN:          vecOf = VEC_ALIGN;
         CS_DSI, CS_DBRK:   vecOf = VEC_DSI;
         default:           vecOf = 16'h0000;
      endcase
   endfunction : vecOf

endpackage : tte_pkg

/* File: src/tte_prio.sv */
// fixed priority picker over pending exception causes
`timescale 1ns/1ps
module tte_prio #(
   parameter int unsigned N = 9
) (
   input  wire logic [N-1:0] req,
   output logic      [3:0]   pick
);

   // lowest request index wins; index i maps to cause i+1
   always_comb begin
      pick = 4'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            pick = 4'(i + 1);
         end
      end
   end

endmodule : tte_prio

/* File: src/tte_assist.sv */
// compare, hash and entry selection values derived from miss registers
`timescale 1ns/1ps
module tte_assist (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic [31:0] missAddr,
   input  wire logic [31:0] missStat,
   output logic      [31:0] cmpVal,
   output logic      [31:0] hash1Val,
   output logic      [31:0] hash2Val,
   output logic      [31:0] lruAVal,
   output logic      [31:0] lruBVal,
   output logic      [31:0] fieldVal
);

   typedef struct packed {
      logic [31:0] cmp;
      logic [31:0] h1;
      logic [31:0] h2;
      logic [31:0] lruA;
      logic [31:0] lruB;
      logic [31:0] fld;
   } tte_assist_s;

   tte_assist_s s_q;
   tte_assist_s s_d;

   // recomputed every cycle, so any change of the miss registers shows
   // one cycle later without extra change detection
   always_comb begin
      s_d      = s_q;
      s_d.cmp  = {missAddr[31:12], 12'h000};
      s_d.h1   = {20'h00000, missAddr[19:12] ^ missAddr[27:20], 4'h0};
      s_d.h2   = ~s_d.h1 & 32'h0000_0ff0;
      s_d.lruA = {27'h0000000, missAddr[16:12]};
      s_d.lruB = {25'h0000000, missAddr[16:12],
                  missStat[tte_pkg::MISS_STATUS_REGISTER_ELEM_LSB +: 2]};
      s_d.fld  = {s_d.lruB[6:0], missAddr[31:12], 5'h00};
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cmpVal   = s_q.cmp;
   assign hash1Val = s_q.h1;
   assign hash2Val = s_q.h2;
   assign lruAVal  = s_q.lruA;
   assign lruBVal  = s_q.lruB;
   assign fieldVal = s_q.fld;

endmodule : tte_assist

/* File: src/tte_exception_unit.sv */
// tlb trap and trace exception unit with its save and miss registers
//
// Functional notes
// - an instruction address breakpoint raises a trace interrupt too.
// - trace clears status bits 1:4, 10, 12:15; rest copied from machine state.
// - trace status bit 11 is 1 for breakpoint, 0 for step or branch.
// - no floating-point assist interrupt is ever raised.
// - tlb miss vectors to 0x1000.
// - miss when relocation on and neither block translation nor tlb hits.
// - tlb miss or store trap sets machine state bit 14.
// - tlb miss or store trap sets the trap walk bit.
// - tlb traps load save address with the faulting instruction address.
// - miss captures the failing fetch or data address.
// - miss status: bit1 data, bit2 fetch, bit6 store, others zero.
// - store trap on relocated store, valid entry, protection ok, clean.
// - tlb store trap vectors to 0x1100.
// - store trap captures the store's data address.
// - store status: bits 4 and 6 set, 7:8 element, others zero.
// - miss register changes recompute compare, hash and entry selection.
// - alignment over data miss over store trap over data storage.
// - fetch tlb miss over instruction storage for the same fetch.
// - breakpoint trace ranks below instruction storage.
// - step or branch trace comes before next instruction's breakpoint.
// - data address breakpoint is the lowest data storage cause.
`timescale 1ns/1ps
module tte_exception_unit (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // pipeline report, one instruction per valid cycle
   input  wire logic        evValid,
   input  wire logic [31:0] instEa,
   input  wire logic [31:0] dataEa,
   input  wire logic [3:0]  condField0,
   input  wire logic        stepTrace,
   input  wire logic        branchTrace,
   input  wire logic        iabrHit,
   input  wire logic        fetchAccess,
   input  wire logic        ibatHit,
   input  wire logic        itlbHit,
   input  wire logic        isiFault,
   input  wire logic        alignFault,
   input  wire logic        dataAccess,
   input  wire logic        dataStore,
   input  wire logic        dbatHit,
   input  wire logic        dtlbHit,
   input  wire logic        protOk,
   input  wire logic        changedBit,
   input  wire logic [1:0]  tlbElement,
   input  wire logic        dsiFault,
   input  wire logic        dabrHit,
   // trap outcome
   output logic             trapTaken,
   output logic      [15:0] trapVector,
   output logic      [3:0]  trapCause,
   output logic      [31:0] machineState,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest
);

   // ******************************************************
   // state
   // ******************************************************
   typedef struct packed {
      logic [31:0] machine_state_register;
      logic [31:0] save_restore_address;
      logic [31:0] save_restore_status;
      logic [31:0] miss_address_register;
      logic [31:0] miss_status_register;
      logic [31:0] rdata;
      logic        waitReq;
      logic        taken;
      logic [15:0] vec;
      logic [3:0]  cause;
   } tte_core_s;

   tte_core_s s_q;
   tte_core_s s_d;

   logic [31:0] cmpVal;
   logic [31:0] hash1Val;
   logic [31:0] hash2Val;
   logic [31:0] lruAVal;
   logic [31:0] lruBVal;
   logic [31:0] fieldVal;
   logic [tte_pkg::NUM_CAUSE-1:0] req;
   logic [3:0]  pick;
   tte_pkg::tte_cause_e sel;
   logic        relocI;
   logic        relocD;
   logic        itlbMiss;
   logic        dtlbMiss;
   logic        tlbStore;

   // ******************************************************
   // helpers
   // ******************************************************
   function automatic logic [31:0] mergeBe(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : mergeBe

   // ******************************************************
   // cause detection
   // ******************************************************
   assign relocI = s_q.machine_state_register[tte_pkg::MSR_IR_POS];
   assign relocD = s_q.machine_state_register[tte_pkg::MSR_DR_POS];

   assign itlbMiss = fetchAccess && relocI && !ibatHit && !itlbHit;
   assign dtlbMiss = dataAccess && relocD && !dbatHit && !dtlbHit;
   assign tlbStore = dataAccess && dataStore && relocD && dtlbHit
                     && protOk && !changedBit;

   // bit order follows the cause enum, highest priority in bit 0;
   // no floating-point assist source exists in the list at all
   always_comb begin
      req    = '0;
      req[0] = stepTrace || branchTrace;
      req[1] = itlbMiss;
      req[2] = isiFault;
      req[3] = iabrHit;
      req[4] = alignFault;
      req[5] = dtlbMiss;
      req[6] = tlbStore;
      req[7] = dsiFault;
      req[8] = dabrHit;
   end

   tte_prio #(
      .N(tte_pkg::NUM_CAUSE)
   ) u_prio (
      .req  (req),
      .pick (pick)
   );

   assign sel = tte_pkg::tte_cause_e'(pick);

   tte_assist u_assist (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .missAddr (s_q.miss_address_register),
      .missStat (s_q.miss_status_register),
      .cmpVal   (cmpVal),
      .hash1Val (hash1Val),
      .hash2Val (hash2Val),
      .lruAVal  (lruAVal),
      .lruBVal  (lruBVal),
      .fieldVal (fieldVal)
   );

   // ******************************************************
   // next state
   // ******************************************************
   always_comb begin
      logic [31:0] baseMsr;
      s_d       = s_q;
      s_d.taken = 1'b0;
      s_d.waitReq = 1'b1;
      baseMsr   = s_q.machine_state_register;

      // bus: one wait cycle, then answer; write lands on the answer edge
      if ((avs_read || avs_write) && s_q.waitReq) begin
         s_d.waitReq = 1'b0;
         case (avs_address)
            tte_pkg::OFF_MSR:   s_d.rdata = s_q.machine_state_register;
            tte_pkg::OFF_SAVE_RESTORE_ADDRESS:  s_d.rdata = s_q.save_restore_address;
            tte_pkg::OFF_SAVE_RESTORE_STATUS:  s_d.rdata = s_q.save_restore_status;
            tte_pkg::OFF_MAR:   s_d.rdata = s_q.miss_address_register;
            tte_pkg::OFF_MISS_STATUS_REGISTER:  s_d.rdata = s_q.miss_status_register;
            tte_pkg::OFF_CMP:   s_d.rdata = cmpVal;
            tte_pkg::OFF_PRIMARY_HASH_ASSIST: s_d.rdata = hash1Val;
            tte_pkg::OFF_SECONDARY_HASH_ASSIST: s_d.rdata = hash2Val;
            tte_pkg::OFF_LRUA:  s_d.rdata = lruAVal;
            tte_pkg::OFF_LRUB:  s_d.rdata = lruBVal;
            tte_pkg::OFF_FIELD: s_d.rdata = fieldVal;
            tte_pkg::OFF_CAUSE: s_d.rdata = {12'h000, s_q.vec, s_q.cause};
            default:            s_d.rdata = 32'h0000_0000;
         endcase
      end
      if (avs_write && !s_q.waitReq) begin
         case (avs_address)
            tte_pkg::OFF_MSR:
               s_d.machine_state_register = mergeBe(s_q.machine_state_register, avs_writedata, avs_byteenable);
            tte_pkg::OFF_SAVE_RESTORE_ADDRESS:
               s_d.save_restore_address = mergeBe(s_q.save_restore_address, avs_writedata, avs_byteenable);
            tte_pkg::OFF_SAVE_RESTORE_STATUS:
               s_d.save_restore_status = mergeBe(s_q.save_restore_status, avs_writedata, avs_byteenable);
            tte_pkg::OFF_MAR:
               s_d.miss_address_register = mergeBe(s_q.miss_address_register, avs_writedata, avs_byteenable);
            tte_pkg::OFF_MISS_STATUS_REGISTER:
               s_d.miss_status_register = mergeBe(s_q.miss_status_register, avs_writedata, avs_byteenable);
            default: begin
            end
         endcase
      end

      // a trap in the same cycle as a bus write wins over it, except a miss register write on a trap that is not a tlb trap
      if (evValid && sel != tte_pkg::CS_NONE) begin
         s_d.taken = 1'b1;
         s_d.cause = pick;
         s_d.vec   = tte_pkg::vecOf(sel);
         s_d.save_restore_address  = instEa;
         baseMsr[tte_pkg::MSR_IR_POS] = 1'b0;
         baseMsr[tte_pkg::MSR_DR_POS] = 1'b0;
         baseMsr[tte_pkg::MSR_EE_POS] = 1'b0;
         baseMsr[tte_pkg::MSR_PR_POS] = 1'b0;
         s_d.machine_state_register = baseMsr;
         case (sel)
            tte_pkg::CS_STEP, tte_pkg::CS_IBRK: begin
               s_d.save_restore_status = s_q.machine_state_register & ~tte_pkg::SAVE_RESTORE_STATUS_TRACE_CLR;
               s_d.save_restore_status[tte_pkg::SAVE_RESTORE_STATUS_BRK_POS] = (sel == tte_pkg::CS_IBRK);
            end
            tte_pkg::CS_ITLB, tte_pkg::CS_DTLB: begin
               s_d.save_restore_status = (s_q.machine_state_register & ~tte_pkg::SAVE_RESTORE_STATUS_TLB_CLR)
                          | {condField0, 28'h0000000};
               s_d.machine_state_register[tte_pkg::MSR_INVBLK_POS] = 1'b1;
               s_d.machine_state_register[tte_pkg::MSR_TW_POS]     = 1'b1;
               s_d.miss_address_register  = (sel == tte_pkg::CS_ITLB) ? instEa : dataEa;
               s_d.miss_status_register = '0;
               s_d.miss_status_register[tte_pkg::MISS_STATUS_REGISTER_DATA_POS]  = (sel == tte_pkg::CS_DTLB);
               s_d.miss_status_register[tte_pkg::MISS_STATUS_REGISTER_FETCH_POS] = (sel == tte_pkg::CS_ITLB);
               s_d.miss_status_register[tte_pkg::MISS_STATUS_REGISTER_STORE_POS] =
                  (sel == tte_pkg::CS_DTLB) && dataStore;
            end
            tte_pkg::CS_TSTORE: begin
               s_d.save_restore_status = (s_q.machine_state_register & ~tte_pkg::SAVE_RESTORE_STATUS_TLB_CLR)
                          | {condField0, 28'h0000000};
               s_d.machine_state_register[tte_pkg::MSR_INVBLK_POS] = 1'b1;
               s_d.machine_state_register[tte_pkg::MSR_TW_POS]     = 1'b1;
               s_d.miss_address_register  = dataEa;
               s_d.miss_status_register = '0;
               s_d.miss_status_register[tte_pkg::MISS_STATUS_REGISTER_PROT_POS]  = 1'b1;
               s_d.miss_status_register[tte_pkg::MISS_STATUS_REGISTER_STORE_POS] = 1'b1;
               s_d.miss_status_register[tte_pkg::MISS_STATUS_REGISTER_ELEM_LSB +: 2] = tlbElement;
            end
            default: begin
               // architectural causes: cause bits left clear for the owner
               s_d.save_restore_status = s_q.machine_state_register & ~tte_pkg::SAVE_RESTORE_STATUS_TRACE_CLR;
            end
         endcase
      end
   end

   // ******************************************************
   // registers
   // ******************************************************
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q         <= '0;
         s_q.machine_state_register     <= tte_pkg::MSR_RESET;
         s_q.save_restore_address    <= tte_pkg::REG_RESET;
         s_q.save_restore_status    <= tte_pkg::REG_RESET;
         s_q.miss_address_register     <= tte_pkg::REG_RESET;
         s_q.miss_status_register    <= tte_pkg::REG_RESET;
         s_q.waitReq <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign trapTaken       = s_q.taken;
   assign trapVector      = s_q.vec;
   assign trapCause       = s_q.cause;
   assign machineState    = s_q.machine_state_register;
   assign avs_readdata    = s_q.rdata;
   assign avs_waitrequest = s_q.waitReq;

endmodule : tte_exception_unit

/* File: dv/tte_checker_asserts.sv */
// port-level checks for the tlb trap exception unit
`timescale 1ns/1ps
module tte_checker (
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic        evValid,
   input wire logic        stepTrace,
   input wire logic        branchTrace,
   input wire logic        iabrHit,
   input wire logic        fetchAccess,
   input wire logic        isiFault,
   input wire logic        alignFault,
   input wire logic        dataAccess,
   input wire logic        dataStore,
   input wire logic        dbatHit,
   input wire logic        dtlbHit,
   input wire logic        protOk,
   input wire logic        changedBit,
   input wire logic        trapTaken,
   input wire logic [15:0] trapVector,
   input wire logic [3:0]  trapCause,
   input wire logic [31:0] machineState,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic noHigher;
   logic isTlb;
   // fetch side left quiet so only data causes compete
   assign noHigher = !stepTrace && !branchTrace && !fetchAccess && !isiFault && !iabrHit
                     && !alignFault;
   assign isTlb = trapCause == 4'h2 || trapCause == 4'h6 || trapCause == 4'h7;
   a_fp_assist_unused: assert property (trapTaken |-> trapVector != 16'h0e00)
      else $error("floating-point assist vector seen");
   a_miss_vector: assert property (trapTaken && (trapCause == 4'h2 || trapCause == 4'h6)
      |-> trapVector == 16'h1000) else $error("tlb miss vector wrong");
   a_store_vector: assert property (trapTaken && trapCause == 4'h7
      |-> trapVector == 16'h1100) else $error("tlb store vector wrong");
   a_trace_vector: assert property (trapTaken && (trapCause == 4'h1 || trapCause == 4'h4)
      |-> trapVector == 16'h0d00) else $error("trace vector wrong");
   a_tlb_msr_bits: assert property (trapTaken && isTlb
      |-> machineState[17] && machineState[18]) else $error("tlb trap state bits not set");
   a_data_miss_taken: assert property (evValid && dataAccess && machineState[4] && !dbatHit
      && !dtlbHit && noHigher |=> trapTaken && trapCause == 4'h6) else $error("data miss lost");
   a_store_trap_taken: assert property (evValid && dataAccess && dataStore && machineState[4]
      && dtlbHit && protOk && !changedBit && noHigher |=> trapTaken && trapCause == 4'h7)
      else $error("store trap lost");
   a_step_first: assert property (evValid && (stepTrace || branchTrace)
      |=> trapTaken && trapCause == 4'h1) else $error("step trace not first");
   a_brk_below_isi: assert property (evValid && iabrHit && isiFault && !stepTrace
      && !branchTrace && !fetchAccess |=> trapCause == 4'h3) else $error("breakpoint over isi");
   a_idle_no_trap: assert property (!evValid |=> !trapTaken)
      else $error("trap without report");
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");
   cover property (trapTaken && trapCause == 4'h6);
   cover property (trapTaken && trapCause == 4'h7);
   cover property (trapTaken && trapCause == 4'h1);
endmodule : tte_checker

bind tte_exception_unit tte_checker tte_checker_inst (
   .sys_clk(sys_clk), .reset_n(reset_n), .evValid(evValid), .stepTrace(stepTrace),
   .branchTrace(branchTrace), .iabrHit(iabrHit), .fetchAccess(fetchAccess),
   .isiFault(isiFault), .alignFault(alignFault), .dataAccess(dataAccess),
   .dataStore(dataStore), .dbatHit(dbatHit), .dtlbHit(dtlbHit), .protOk(protOk),
   .changedBit(changedBit), .trapTaken(trapTaken), .trapVector(trapVector),
   .trapCause(trapCause), .machineState(machineState), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

/* File: dv/tte_pipe_model.sv */
// behavioural pipeline and translation model reporting one instruction per call
`timescale 1ns/1ps
module tte_pipe_model (
   input  wire logic        sys_clk,
   output logic             evValid,
   output logic      [31:0] instEa,
   output logic      [31:0] dataEa,
   output logic      [3:0]  condField0,
   output logic      [15:0] flags,
   output logic      [1:0]  tlbElement
);
   initial begin
      evValid    = 1'b0;
      instEa     = 32'h0;
      dataEa     = 32'h0;
      condField0 = 4'h0;
      flags      = 16'h0;
      tlbElement = 2'h0;
   end
   // flags: step branch iabr fetch instruction_block_translation itlb isi align dacc store data_block_translation dtlb prot chg dsi dabr
   task automatic send(input logic [15:0] f,
                       input logic [31:0] ia,
                       input logic [31:0] da,
                       input logic [3:0]  cr,
                       input logic [1:0]  el);
      @(posedge sys_clk);
      evValid    <= 1'b1;
      flags      <= f;
      instEa     <= ia;
      dataEa     <= da;
      condField0 <= cr;
      tlbElement <= el;
      @(posedge sys_clk);
      // stale qualifiers are inverted so nothing leans on held values
      evValid    <= 1'b0;
      flags      <= ~f;
      instEa     <= ~ia;
      dataEa     <= ~da;
      condField0 <= ~cr;
      tlbElement <= ~el;
   endtask : send
endmodule : tte_pipe_model

/* File: dv/tb_top.sv */
// self-checking bench for the tlb trap exception unit
`timescale 1ns/1ps
module tb_top;
   logic        sys_clk, reset_n, evValid, trapTaken, avs_read, avs_write, avs_waitrequest;
   logic [31:0] instEa, dataEa, machineState, avs_writedata, avs_readdata, rdData;
   logic [31:0] msrV, ia, da, expS, expMar, expMisr;
   logic [15:0] flags, trapVector;
   logic [3:0]  condField0, trapCause, c;
   logic [1:0]  tlbElement;
   logic [5:0]  avs_address;
   logic        tlb;
   int          num_errors, check_count;
   localparam int NCASE = 21;
   localparam logic [31:0] MSR_ON = 32'h8d49_c031;
   localparam logic [15:0] VEC [10] = '{16'h0000, 16'h0d00, 16'h1000, 16'h0400, 16'h0d00,
                                        16'h0600, 16'h1000, 16'h1100, 16'h0300, 16'h0300};
   // last two rows run with relocation off
   localparam logic [15:0] FLG [NCASE] = '{16'h8000, 16'h4000, 16'h2000, 16'h2200, 16'ha000,
      16'h1200, 16'h1000, 16'h1800, 16'h1400, 16'h0180, 16'h0082, 16'h00c0, 16'h00a0,
      16'h00da, 16'h00dc, 16'h00d0, 16'h0003, 16'h0001, 16'h0000, 16'h1000, 16'h0080};
   localparam logic [3:0] EXPC [NCASE] = '{4'h1, 4'h1, 4'h4, 4'h3, 4'h1, 4'h2, 4'h2, 4'h0,
      4'h0, 4'h5, 4'h6, 4'h6, 4'h0, 4'h7, 4'h0, 4'h0, 4'h8, 4'h9, 4'h0, 4'h0, 4'h0};

   tte_pipe_model tte_pipe_model_inst (.sys_clk(sys_clk), .evValid(evValid), .instEa(instEa),
      .dataEa(dataEa), .condField0(condField0), .flags(flags), .tlbElement(tlbElement));

   tte_exception_unit tte_exception_unit_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .evValid(evValid), .instEa(instEa),
      .dataEa(dataEa), .condField0(condField0), .stepTrace(flags[15]),
      .branchTrace(flags[14]), .iabrHit(flags[13]), .fetchAccess(flags[12]),
      .ibatHit(flags[11]), .itlbHit(flags[10]), .isiFault(flags[9]), .alignFault(flags[8]),
      .dataAccess(flags[7]), .dataStore(flags[6]), .dbatHit(flags[5]), .dtlbHit(flags[4]),
      .protOk(flags[3]), .changedBit(flags[2]), .tlbElement(tlbElement),
      .dsiFault(flags[1]), .dabrHit(flags[0]), .trapTaken(trapTaken),
      .trapVector(trapVector), .trapCause(trapCause), .machineState(machineState),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   // ******************************************************
   // helpers
   // ******************************************************
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // request held until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [5:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address   <= addr;
      avs_writedata <= wd;
      avs_read      <= !wr;
      avs_write     <= wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdData = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         num_errors++;
         test_done();
      end
   endtask : bus

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ******************************************************
   // main sequence
   // ******************************************************
   initial begin
      reset_n       = 1'b0;
      avs_address   = 6'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      num_errors    = 0;
      check_count   = 0;
      expMar        = 32'h0;
      expMisr       = 32'h0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int a = 0; a < 5; a++) begin
         bus(1'b0, 6'(a * 4), 32'h0);
         check("reset value", rdData, 32'h0);
      end
      bus(1'b1, 6'h3c, 32'hffff_ffff);
      bus(1'b0, 6'h3c, 32'h0);
      check("unmapped", rdData, 32'h0);
      for (int i = 0; i < NCASE; i++) begin
         msrV = (i < NCASE - 2) ? MSR_ON : (MSR_ON & ~32'h0000_0030);
         ia   = 32'h4000_0004 | 32'(i << 12);
         da   = 32'h8765_0008 ^ 32'(i << 14);
         c    = EXPC[i];
         tlb  = (c == 4'h2 || c == 4'h6 || c == 4'h7);
         bus(1'b1, tte_pkg::OFF_MSR, msrV);
         tte_pipe_model_inst.send(FLG[i], ia, da, 4'(i), 2'(i));
         #1;
         check("trapTaken", 32'(trapTaken), 32'(c != 4'h0));
         if (c != 4'h0) begin
            expS = tlb ? ({4'(i), 28'h0} | (msrV & ~tte_pkg::SAVE_RESTORE_STATUS_TLB_CLR))
                       : ((msrV & ~tte_pkg::SAVE_RESTORE_STATUS_TRACE_CLR) | (32'(c == 4'h4) << 20));
            if (c == 4'h2) begin
               expMar  = ia;
               expMisr = 32'h2000_0000;
            end else if (c == 4'h6) begin
               expMar  = da;
               expMisr = 32'h4000_0000 | (32'(FLG[i][6]) << 25);
            end else if (c == 4'h7) begin
               expMar  = da;
               expMisr = 32'h0a00_0000 | (32'(i % 4) << 23);
            end
            check("trapCause", 32'(trapCause), 32'(c));
            check("trapVector", 32'(trapVector), 32'(VEC[c]));
            check("machineState", machineState, (msrV & ~32'h0000_c030)
                  | (tlb ? 32'h0006_0000 : 32'h0));
            bus(1'b0, tte_pkg::OFF_SAVE_RESTORE_ADDRESS, 32'h0);
            check("save address", rdData, ia);
            bus(1'b0, tte_pkg::OFF_SAVE_RESTORE_STATUS, 32'h0);
            check("save status", rdData, expS);
         end
         bus(1'b0, tte_pkg::OFF_MAR, 32'h0);
         check("miss address", rdData, expMar);
         bus(1'b0, tte_pkg::OFF_MISS_STATUS_REGISTER, 32'h0);
         check("miss status", rdData, expMisr);
         if (tlb) begin
            bus(1'b0, tte_pkg::OFF_CMP, 32'h0);
            check("compare assist", rdData, {expMar[31:12], 12'h000});
         end
      end
      test_done();
   end
endmodule : tb_top
